// *** src/serial_cfg_defines.vh ***
// Constants for the serial configuration command interpreter
// How it works
// - Link runs 115200 baud, eight bits, no parity
// - Replies carry bare value, leading zeros kept
// - Printable ASCII, every line ends CR LF
// - Question mark line sends the help listing
// - Boot loads parameter mirror from flash
// - Serial settings touch mirror only until Q
// - Panel return to top saves parameters
// - Serial commands accepted while enabled, no lockout
// - Pulse setup applies at next enable cycle
// - R, P, X give assignments and version
// - Lower-case v, t, c, w, g plus selectors read stored parameter values
// - Dump gives up to 64 events, 25 bytes
// - x and y give fault words, 8 hex
// - Upper-case letter plus selectors sets three hex
// - Q writes parameters and history to flash
// - History saved on enable drop or 2.5 hours
// - S clears log, then snapshots every change
// - s stops logging, required before dump
// - r clears latches unless fault persists
// - Z then Y clears tube odometers, saves
// - z then Y clears duplexer odometer, saves
// - F restores factory parameter values
`ifndef SERIAL_CFG_DEFINES_VH
`define SERIAL_CFG_DEFINES_VH
`define CLK_HZ        40'd100000000
`define BAUD_RATE     40'd115200
`define BAUD_CYC      (`CLK_HZ / `BAUD_RATE)
`define HIST_TIME_DH  40'd25
`define SEC_PER_DH    40'd360
`define HIST_CYC      (`HIST_TIME_DH * `SEC_PER_DH * `CLK_HZ)
`define CH_CR         8'h0D
`define CH_LF         8'h0A
`define CH_SP         8'h20
`define CH_ERR        8'h3F
`define CH_0          8'h30
`define CH_A10        8'h37
`define CASE_BIT      8'h20
`define LINE_MAX      4'h8
`define PARAM_WORDS   128
`define PARAM_LAST    7'h7F
`define PARAM_FACTORY 12'h000
`define PB_DAC        7'h00
`define PB_TMR        7'h20
`define PB_DIODE      7'h30
`define PB_PCALC      7'h34
`define PB_PG         7'h40
`define N_DAC_DEV     4'h4
`define N_DAC_SUB     4'h8
`define N_TMR         8'h0B
`define N_DIODE       4'h4
`define N_PCALC       4'h2
`define N_PG_FN       4'h4
`define EVT_MAX       7'h40
`define EVT_LEN       7'h19
`define DP_IDX_HI     7'h02
`define DP_SP1        7'h03
`define DP_BITS_HI    7'h0F
`define DP_SP2        7'h10
`define DP_TS_HI      7'h18
`define HEX_FAULT_LEN 7'h08
`define HEX_CNT_LEN   7'h02
`define HEX_PRM_LEN   7'h03
`define TXT_HELP "vdc tdc cd wc gcf n d x y R P X Vdcnnn Tdcnnn Cdnnn Wcnnn Gcfnnn Q S s r Z z Y F"
`define LEN_HELP      7'h50
`define TXT_DAC       "DAC d0-3 c0-7"
`define LEN_DAC       7'h0D
`define TXT_TMR       "TMR dc 00-0A"
`define LEN_TMR       7'h0C
`define TXT_VER       "V1.0 BUILD0"
`define LEN_VER       7'h0B
`endif

// *** src/serial_rx.v ***
// Asynchronous serial receiver, 8 data bits, no parity
`timescale 1ns/10ps
module serial_rx (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       rxd,
  output reg  [7:0] rx_data,
  output reg        rx_valid
);
`include "serial_cfg_defines.vh"
  localparam [39:0] DIV_FULL = `BAUD_CYC;
  localparam [9:0]  DIV_M1   = DIV_FULL[9:0] - 10'h001;
  localparam [9:0]  HALF     = DIV_FULL[10:1];
  reg       busy_reg;
  reg [9:0] cnt_reg;
  reg [3:0] bit_reg;
  reg [7:0] sh_reg;
  // Start detect, mid-bit sampling, stop check; bad frames dropped
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 10'h000;
      bit_reg  <= 4'h0;
      sh_reg   <= 8'h00;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!busy_reg) begin
        if (!rxd) begin
          busy_reg <= 1'b1;
          cnt_reg  <= HALF;
          bit_reg  <= 4'h0;
        end
      end else if (cnt_reg != 10'h000) begin
        cnt_reg <= cnt_reg - 10'h001;
      end else begin
        cnt_reg <= DIV_M1;
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg == 4'h0) begin
          if (rxd) busy_reg <= 1'b0; // False start
        end else if (bit_reg == 4'h9) begin
          busy_reg <= 1'b0;
          if (rxd) begin
            rx_data  <= sh_reg;
            rx_valid <= 1'b1;
          end
        end else begin
          sh_reg <= {rxd, sh_reg[7:1]};
        end
      end
    end
  end
endmodule

// *** src/serial_tx.v ***
// Asynchronous serial transmitter, 8 data bits, no parity
`timescale 1ns/10ps
module serial_tx (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [7:0] tx_data,
  input  wire       tx_start,
  output reg        txd,
  output reg        tx_busy
);
`include "serial_cfg_defines.vh"
  localparam [39:0] DIV_FULL = `BAUD_CYC;
  localparam [9:0]  DIV_M1   = DIV_FULL[9:0] - 10'h001;
  reg [9:0] cnt_reg;
  reg [3:0] bit_reg;
  reg [8:0] sh_reg;
  // Start bit, eight data bits LSB first, one stop bit
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txd     <= 1'b1;
      tx_busy <= 1'b0;
      cnt_reg <= 10'h000;
      bit_reg <= 4'h0;
      sh_reg  <= 9'h1FF;
    end else if (!tx_busy) begin
      if (tx_start) begin
        tx_busy <= 1'b1;
        txd     <= 1'b0;
        sh_reg  <= {1'b1, tx_data};
        cnt_reg <= DIV_M1;
        bit_reg <= 4'h0;
      end
    end else if (cnt_reg != 10'h000) begin
      cnt_reg <= cnt_reg - 10'h001;
    end else begin
      cnt_reg <= DIV_M1;
      if (bit_reg == 4'h9) begin
        tx_busy <= 1'b0;
      end else begin
        txd     <= sh_reg[0];
        sh_reg  <= {1'b1, sh_reg[8:1]};
        bit_reg <= bit_reg + 4'h1;
      end
    end
  end
endmodule

// *** src/serial_cfg_cmd.v ***
// Serial command interpreter with parameter mirror, logger and fault latches
`timescale 1ns/10ps
`include "serial_cfg_defines.vh"
module serial_cfg_cmd #(
  parameter [39:0] HIST_PERIOD = `HIST_CYC
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        rxd,
  output wire        txd,
  input  wire        enabled,
  input  wire        panel_top,
  input  wire        fault_rst_ext,
  input  wire [31:0] fault_now,
  input  wire [47:0] evt_bits,
  input  wire [11:0] flash_rdata,
  input  wire        flash_ack,
  output reg  [6:0]  flash_addr,
  output reg  [11:0] flash_wdata,
  output reg         flash_rd,
  output reg         flash_wr,
  output reg         booted,
  output reg         hist_save,
  output reg         odo_clr_tube,
  output reg         odo_clr_dup,
  output reg         pg_reload,
  input  wire [6:0]  prm_addr,
  output reg  [11:0] prm_data,
  output reg  [31:0] fault_latch
);
  localparam [1:0] C_COLLECT = 2'd0;
  localparam [1:0] C_EXEC    = 2'd1;
  localparam [1:0] C_REPLY   = 2'd2;
  localparam [1:0] T_IDLE = 2'd0;
  localparam [1:0] T_BODY = 2'd1;
  localparam [1:0] T_CR   = 2'd2;
  localparam [1:0] T_LF   = 2'd3;
  localparam [1:0] M_TEXT = 2'd0;
  localparam [1:0] M_HEX  = 2'd1;
  localparam [1:0] M_DUMP = 2'd2;
  localparam [1:0] M_ERR  = 2'd3;
  localparam [1:0] F_BOOT = 2'd0;
  localparam [1:0] F_IDLE = 2'd1;
  localparam [1:0] F_WR   = 2'd2;

  // ------------------------------------------------------------
  // Storage and state
  // ------------------------------------------------------------
  reg [11:0] pmem [0:`PARAM_WORDS-1];
  reg [79:0] elog [0:63];
  reg [63:0] lb_reg;
  reg [3:0]  len_reg;
  reg        ovf_reg;
  reg [1:0]  c_state_reg;
  reg [1:0]  t_state_reg;
  reg [1:0]  t_mode_reg;
  reg [1:0]  t_txt_reg;
  reg [6:0]  t_pos_reg;
  reg [6:0]  t_len_reg;
  reg [47:0] t_hex_reg;
  reg [5:0]  t_evt_reg;
  reg        tx_start_reg;
  reg [7:0]  tx_data_reg;
  reg [1:0]  conf_reg;
  reg        set_we_reg;
  reg [6:0]  set_addr_reg;
  reg [11:0] set_val_reg;
  reg        factory_reg;
  reg        save_req_reg;
  reg        hist_req_reg;
  reg        log_start_reg;
  reg        log_stop_reg;
  reg        fault_clr_reg;
  reg [1:0]  f_state_reg;
  reg        pend_reg;
  reg        ena_d_reg;
  reg [39:0] hist_tmr_reg;
  reg [31:0] first_reg;
  reg        log_on_reg;
  reg [6:0]  ev_cnt_reg;
  reg [47:0] ev_prev_reg;
  reg [31:0] ts_reg;
  wire [7:0] rx_ch;
  wire       rx_valid;
  wire       tx_busy;
  integer    i;

  serial_rx u_rx (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .rxd      (rxd),
    .rx_data  (rx_ch),
    .rx_valid (rx_valid)
  );

  serial_tx u_tx (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .tx_data  (tx_data_reg),
    .tx_start (tx_start_reg),
    .txd      (txd),
    .tx_busy  (tx_busy)
  );

  // ------------------------------------------------------------
  // Line decode
  // ------------------------------------------------------------
  function [4:0] hexv;
    input [7:0] ch;
    begin
      if (ch >= "0" && ch <= "9") hexv = {1'b1, ch[3:0]};
      else if ((ch >= "A" && ch <= "F") || (ch >= "a" && ch <= "f")) hexv = {1'b1, ch[3:0] + 4'h9};
      else hexv = 5'h00;
    end
  endfunction

  function [7:0] hexa;
    input [3:0] n;
    begin
      if (n < 4'hA) hexa = `CH_0 + {4'h0, n};
      else hexa = `CH_A10 + {4'h0, n};
    end
  endfunction

  wire [7:0]  c0 = lb_reg[7:0];
  wire [4:0]  s1 = hexv(lb_reg[15:8]);
  wire [4:0]  s2 = hexv(lb_reg[23:16]);
  wire        is_set = (c0 >= "A") && (c0 <= "Z");
  wire [7:0]  tix = {1'b0, s1[3:0], 3'b000} + {4'h0, s2[3:0]};
  reg         pk_ok;
  reg  [6:0]  pk_addr;
  reg  [3:0]  pk_nsel;
  wire [63:0] val_sh = lb_reg >> {pk_nsel + 4'h1, 3'b000};
  wire [4:0]  v2 = hexv(val_sh[7:0]);
  wire [4:0]  v1 = hexv(val_sh[15:8]);
  wire [4:0]  v0 = hexv(val_sh[23:16]);
  wire        val_ok = v2[4] & v1[4] & v0[4];

  // Parameter selector decode, shared by inquiry and setting forms
  always @* begin
    pk_ok   = 1'b0;
    pk_addr = `PB_DAC;
    pk_nsel = 4'h1;
    case (c0 | `CASE_BIT)
      "v": begin
        pk_nsel = 4'h2;
        pk_ok   = s1[4] & s2[4] & (s1[3:0] < `N_DAC_DEV) & (s2[3:0] < `N_DAC_SUB);
        pk_addr = `PB_DAC + {2'b00, s1[1:0], s2[2:0]};
      end
      "t": begin
        pk_nsel = 4'h2;
        pk_ok   = s1[4] & s2[4] & (tix < `N_TMR);
        pk_addr = `PB_TMR + tix[6:0];
      end
      "c": begin
        pk_ok   = s1[4] & (s1[3:0] < `N_DIODE);
        pk_addr = `PB_DIODE + {5'h00, s1[1:0]};
      end
      "w": begin
        pk_ok   = s1[4] & (s1[3:0] < `N_PCALC);
        pk_addr = `PB_PCALC + {6'h00, s1[0]};
      end
      "g": begin
        pk_nsel = 4'h2;
        pk_ok   = s1[4] & s2[4] & (s2[3:0] < `N_PG_FN);
        pk_addr = `PB_PG + {1'b0, s1[3:0], s2[1:0]};
      end
      default: pk_ok = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Reply character generator
  // ------------------------------------------------------------
  reg  [639:0] tbuf;
  reg  [6:0]   tlen;
  reg  [47:0]  dsrc;
  reg  [6:0]   dk;
  reg  [7:0]   cur_ch;
  wire [79:0]  rec = elog[t_evt_reg];
  wire [6:0]   hk = t_len_reg - 7'h01 - t_pos_reg;
  wire [47:0]  hex_sh = t_hex_reg >> {hk, 2'b00};
  wire [47:0]  dmp_sh = dsrc >> {dk, 2'b00};
  wire [639:0] txt_sh = tbuf >> {tlen - 7'h01 - t_pos_reg, 3'b000};

  always @* begin
    tbuf = `TXT_HELP;
    tlen = `LEN_HELP;
    case (t_txt_reg)
      2'd1: begin
        tbuf = `TXT_DAC;
        tlen = `LEN_DAC;
      end
      2'd2: begin
        tbuf = `TXT_TMR;
        tlen = `LEN_TMR;
      end
      2'd3: begin
        tbuf = `TXT_VER;
        tlen = `LEN_VER;
      end
      default: tlen = `LEN_HELP;
    endcase
    // Dump line: iii bbbbbbbbbbbb tttttttt
    if (t_pos_reg <= `DP_IDX_HI) begin
      dsrc = {42'h0, t_evt_reg};
      dk   = `DP_IDX_HI - t_pos_reg;
    end else if (t_pos_reg <= `DP_BITS_HI) begin
      dsrc = rec[79:32];
      dk   = `DP_BITS_HI - t_pos_reg;
    end else begin
      dsrc = {16'h0000, rec[31:0]};
      dk   = `DP_TS_HI - t_pos_reg;
    end
    case (t_mode_reg)
      M_TEXT:  cur_ch = txt_sh[7:0];
      M_HEX:   cur_ch = hexa(hex_sh[3:0]);
      M_DUMP:  cur_ch = (t_pos_reg == `DP_SP1 || t_pos_reg == `DP_SP2) ? `CH_SP : hexa(dmp_sh[3:0]);
      default: cur_ch = `CH_ERR;
    endcase
  end

  // ------------------------------------------------------------
  // Command collection, execution and reply sequencing
  // ------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lb_reg        <= 64'h0;
      len_reg       <= 4'h0;
      ovf_reg       <= 1'b0;
      c_state_reg   <= C_COLLECT;
      t_state_reg   <= T_IDLE;
      t_mode_reg    <= M_TEXT;
      t_txt_reg     <= 2'd0;
      t_pos_reg     <= 7'h00;
      t_len_reg     <= 7'h00;
      t_hex_reg     <= 48'h0;
      t_evt_reg     <= 6'h00;
      tx_start_reg  <= 1'b0;
      tx_data_reg   <= 8'h00;
      conf_reg      <= 2'd0;
      set_we_reg    <= 1'b0;
      set_addr_reg  <= 7'h00;
      set_val_reg   <= 12'h000;
      factory_reg   <= 1'b0;
      save_req_reg  <= 1'b0;
      hist_req_reg  <= 1'b0;
      log_start_reg <= 1'b0;
      log_stop_reg  <= 1'b0;
      fault_clr_reg <= 1'b0;
      odo_clr_tube  <= 1'b0;
      odo_clr_dup   <= 1'b0;
    end else begin
      tx_start_reg  <= 1'b0;
      set_we_reg    <= 1'b0;
      factory_reg   <= 1'b0;
      save_req_reg  <= 1'b0;
      hist_req_reg  <= 1'b0;
      log_start_reg <= 1'b0;
      log_stop_reg  <= 1'b0;
      fault_clr_reg <= 1'b0;
      odo_clr_tube  <= 1'b0;
      odo_clr_dup   <= 1'b0;
      case (c_state_reg)
        C_COLLECT: begin
          // Accepted whatever the enable state; no lockout here
          if (rx_valid) begin
            if (rx_ch == `CH_CR) begin
              if (len_reg != 4'h0) c_state_reg <= C_EXEC;
            end else if (rx_ch != `CH_LF) begin
              if (len_reg < `LINE_MAX) begin
                lb_reg[{len_reg[2:0], 3'b000} +: 8] <= rx_ch;
                len_reg <= len_reg + 4'h1;
              end else begin
                ovf_reg <= 1'b1;
              end
            end
          end
        end
        C_EXEC: begin
          c_state_reg <= C_REPLY;
          t_state_reg <= T_CR;
          t_pos_reg   <= 7'h00;
          t_evt_reg   <= 6'h00;
          len_reg     <= 4'h0;
          ovf_reg     <= 1'b0;
          conf_reg    <= 2'd0;
          t_mode_reg  <= M_ERR;
          if (ovf_reg) begin
            t_state_reg <= T_BODY;
            t_len_reg   <= 7'h01;
          end else if (len_reg == 4'h1 && (c0 == "?" || c0 == "R" || c0 == "P" || c0 == "X")) begin
            t_mode_reg  <= M_TEXT;
            t_state_reg <= T_BODY;
            t_txt_reg   <= (c0 == "?") ? 2'd0 : (c0 == "R") ? 2'd1 : (c0 == "P") ? 2'd2 : 2'd3;
            t_len_reg   <= (c0 == "?") ? `LEN_HELP : (c0 == "R") ? `LEN_DAC : (c0 == "P") ? `LEN_TMR : `LEN_VER;
          end else if (len_reg == 4'h1 && (c0 == "x" || c0 == "y" || c0 == "n")) begin
            t_mode_reg  <= M_HEX;
            t_state_reg <= T_BODY;
            t_hex_reg   <= (c0 == "x") ? {16'h0, fault_now} : (c0 == "y") ? {16'h0, first_reg} : {41'h0, ev_cnt_reg};
            t_len_reg   <= (c0 == "n") ? `HEX_CNT_LEN : `HEX_FAULT_LEN;
          end else if (len_reg == 4'h1 && c0 == "d") begin
            if (log_on_reg) begin
              t_state_reg <= T_BODY;
              t_len_reg   <= 7'h01;
            end else begin
              t_mode_reg  <= M_DUMP;
              t_len_reg   <= `EVT_LEN;
              if (ev_cnt_reg != 7'h00) t_state_reg <= T_BODY;
            end
          end else if (len_reg == 4'h1 && c0 == "Q") begin
            save_req_reg <= 1'b1;
            hist_req_reg <= 1'b1;
          end else if (len_reg == 4'h1 && c0 == "S") begin
            log_start_reg <= 1'b1;
          end else if (len_reg == 4'h1 && c0 == "s") begin
            log_stop_reg <= 1'b1;
          end else if (len_reg == 4'h1 && c0 == "r") begin
            fault_clr_reg <= 1'b1;
          end else if (len_reg == 4'h1 && c0 == "Z") begin
            conf_reg <= 2'd1;
          end else if (len_reg == 4'h1 && c0 == "z") begin
            conf_reg <= 2'd2;
          end else if (len_reg == 4'h1 && c0 == "Y" && conf_reg != 2'd0) begin
            odo_clr_tube <= (conf_reg == 2'd1);
            odo_clr_dup  <= (conf_reg == 2'd2);
            save_req_reg <= 1'b1;
            hist_req_reg <= 1'b1;
          end else if (len_reg == 4'h1 && c0 == "F") begin
            factory_reg <= 1'b1;
          end else if (pk_ok && !is_set && len_reg == pk_nsel + 4'h1) begin
            t_mode_reg  <= M_HEX;
            t_state_reg <= T_BODY;
            t_hex_reg   <= {36'h0, pmem[pk_addr]};
            t_len_reg   <= `HEX_PRM_LEN;
          end else if (pk_ok && is_set && val_ok && len_reg == pk_nsel + 4'h4) begin
            set_we_reg   <= 1'b1;
            set_addr_reg <= pk_addr;
            set_val_reg  <= {v2[3:0], v1[3:0], v0[3:0]};
          end else begin
            t_state_reg <= T_BODY;
            t_len_reg   <= 7'h01;
          end
        end
        default: begin
          if (t_state_reg == T_IDLE) c_state_reg <= C_COLLECT;
        end
      endcase
      // One character per transmitter slot, every line closed by CR LF
      if (t_state_reg != T_IDLE && !tx_busy && !tx_start_reg) begin
        tx_start_reg <= 1'b1;
        case (t_state_reg)
          T_BODY: begin
            tx_data_reg <= cur_ch;
            if (t_pos_reg == t_len_reg - 7'h01) t_state_reg <= T_CR;
            else t_pos_reg <= t_pos_reg + 7'h01;
          end
          T_CR: begin
            tx_data_reg <= `CH_CR;
            t_state_reg <= T_LF;
          end
          default: begin
            tx_data_reg <= `CH_LF;
            if (t_mode_reg == M_DUMP && ({1'b0, t_evt_reg} + 7'h01) < ev_cnt_reg) begin
              t_evt_reg   <= t_evt_reg + 6'h01;
              t_pos_reg   <= 7'h00;
              t_state_reg <= T_BODY;
            end else begin
              t_state_reg <= T_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Parameter mirror and flash transfers
  // ------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      f_state_reg <= F_BOOT;
      flash_addr  <= 7'h00;
      flash_wdata <= 12'h000;
      flash_rd    <= 1'b0;
      flash_wr    <= 1'b0;
      booted      <= 1'b0;
      pend_reg    <= 1'b0;
      prm_data    <= 12'h000;
    end else begin
      prm_data <= pmem[prm_addr];
      pend_reg <= pend_reg | save_req_reg | panel_top;
      case (f_state_reg)
        F_BOOT: begin
          flash_rd <= 1'b1;
          if (flash_rd && flash_ack) begin
            pmem[flash_addr] <= flash_rdata;
            if (flash_addr == `PARAM_LAST) begin
              flash_rd    <= 1'b0;
              booted      <= 1'b1;
              f_state_reg <= F_IDLE;
            end
            flash_addr <= flash_addr + 7'h01;
          end
        end
        F_IDLE: begin
          if (pend_reg) begin
            pend_reg    <= save_req_reg | panel_top;
            flash_addr  <= 7'h00;
            flash_wdata <= pmem[0];
            flash_wr    <= 1'b1;
            f_state_reg <= F_WR;
          end
        end
        default: begin
          if (flash_ack) begin
            if (flash_addr == `PARAM_LAST) begin
              flash_wr    <= 1'b0;
              f_state_reg <= F_IDLE;
            end
            flash_addr  <= flash_addr + 7'h01;
            flash_wdata <= pmem[flash_addr + 7'h01];
          end
        end
      endcase
      if (factory_reg) begin
        for (i = 0; i < `PARAM_WORDS; i = i + 1) begin
          pmem[i] <= `PARAM_FACTORY;
        end
      end
      if (set_we_reg) pmem[set_addr_reg] <= set_val_reg;
    end
  end

  // ------------------------------------------------------------
  // History saves and pulse setup reload
  // ------------------------------------------------------------
  wire hist_fire = hist_req_reg | (ena_d_reg & ~enabled) | (hist_tmr_reg == HIST_PERIOD - 40'h1);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ena_d_reg    <= 1'b0;
      pg_reload    <= 1'b0;
      hist_save    <= 1'b0;
      hist_tmr_reg <= 40'h0;
    end else begin
      ena_d_reg    <= enabled;
      pg_reload    <= enabled & ~ena_d_reg;
      hist_save    <= hist_fire;
      hist_tmr_reg <= hist_fire ? 40'h0 : hist_tmr_reg + 40'h1;
    end
  end

  // ------------------------------------------------------------
  // Fault latches; a present fault beats any clear
  // ------------------------------------------------------------
  wire fault_clr = fault_clr_reg | fault_rst_ext;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_latch <= 32'h0;
      first_reg   <= 32'h0;
    end else begin
      fault_latch <= (fault_latch & ~{32{fault_clr}}) | fault_now;
      if (fault_clr) first_reg <= fault_now;
      else if (fault_latch == 32'h0 && fault_now != 32'h0) first_reg <= fault_now;
    end
  end

  // ------------------------------------------------------------
  // Event logger
  // ------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      log_on_reg  <= 1'b0;
      ev_cnt_reg  <= 7'h00;
      ev_prev_reg <= 48'h0;
      ts_reg      <= 32'h0;
    end else begin
      ts_reg      <= ts_reg + 32'h1;
      ev_prev_reg <= evt_bits;
      if (log_start_reg) begin
        ev_cnt_reg <= 7'h00;
        log_on_reg <= 1'b1;
      end else if (log_stop_reg) begin
        log_on_reg <= 1'b0;
      end else if (log_on_reg && evt_bits != ev_prev_reg && ev_cnt_reg < `EVT_MAX) begin
        elog[ev_cnt_reg[5:0]] <= {evt_bits, ts_reg};
        ev_cnt_reg <= ev_cnt_reg + 7'h01;
      end
    end
  end
endmodule

// *** dv/serial_cfg_cmd_monitor.sv ***
// Pin-level checker for the command interpreter
`timescale 1ns/10ps
module serial_cfg_cmd_monitor (
  input logic        clk,
  input logic        sys_rst,
  input logic        enabled,
  input logic        panel_top,
  input logic        fault_rst_ext,
  input logic [31:0] fault_now,
  input logic        flash_rd,
  input logic        flash_wr,
  input logic        booted,
  input logic        hist_save,
  input logic        pg_reload,
  input logic [31:0] fault_latch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  boot_read_a: assert property (flash_rd |-> !booted) else $error("boot read after load");
  save_after_boot_a: assert property (flash_wr |-> booted && !flash_rd) else $error("early save");
  reload_rise_a: assert property ($rose(enabled) |-> ##[1:2] pg_reload) else $error("no reload");
  reload_only_a: assert property (pg_reload |-> $past(enabled) && !$past(enabled, 2)) else $error("stray reload");
  hist_drop_a: assert property ($fell(enabled) |-> ##[1:2] hist_save) else $error("no history save");
  panel_save_a: assert property (panel_top && booted |-> ##[1:3] flash_wr) else $error("no panel save");
  latch_set_a: assert property (|fault_now |=> (fault_latch & $past(fault_now)) == $past(fault_now))
    else $error("fault not latched");
  latch_clr_a: assert property (fault_rst_ext && fault_now == 32'h0 |=> fault_latch == 32'h0)
    else $error("latch not cleared");
  hist_cov: cover property (hist_save);
  reload_cov: cover property (pg_reload);
  save_cov: cover property ($fell(flash_wr));
endmodule

// *** dv/host_uart.sv ***
// Remote host model: 8N1 characters at 115200 baud
`timescale 1ns/10ps
module host_uart (
  input  wire  clk,
  input  wire  txd,
  output logic rxd
);
  localparam int BIT = 868;
  initial rxd = 1'b1;
  // Start bit, data LSB first, stop bit, idle high between characters
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1 rxd = f[i];
      repeat (BIT - 1) @(posedge clk);
    end
  endtask
  // Sample mid-bit; idle timeout yields a garbage character
  task automatic recv(output logic [7:0] c);
    int n;
    n = 0;
    while (txd === 1'b1 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      c[i] = txd;
    end
    repeat (BIT) @(posedge clk); // Park in the stop bit
  endtask
endmodule

// *** dv/tb_serial_cfg_cmd.sv ***
// Self-checking bench for the serial command interpreter
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; $display("Error %0t: %h vs %h", $time, a, b); end end
module tb_serial_cfg_cmd;
  logic clk = 0, sys_rst = 1, enabled = 0, panel_top = 0, fault_rst_ext = 0;
  logic [31:0] fault_now = 32'h0;
  logic [6:0]  prm_addr = 7'h00;
  logic [7:0]  r0, r1;
  wire         txd, rxd, flash_rd, flash_wr, booted, hist_save, pg_reload;
  wire [6:0]   flash_addr;
  wire [11:0]  flash_wdata, prm_data;
  wire [31:0]  fault_latch;
  wire         flash_ack = flash_rd | flash_wr;
  wire [11:0]  flash_rdata = 12'hA50 ^ {5'h00, flash_addr};
  int          errors = 0, checks_done = 0, n_wr = 0, n_hist = 0, n_rl = 0, w0, h0, h1;
  always #5 clk = ~clk;
  // Pulse and save activity counters
  always @(posedge clk) begin
    n_wr += flash_wr;
    n_hist += hist_save;
    n_rl += pg_reload;
  end
  host_uart host_i (.clk(clk), .txd(txd), .rxd(rxd));
  serial_cfg_cmd #(.HIST_PERIOD(40'd20000)) serial_cfg_cmd_i (.clk(clk), .sys_rst(sys_rst), .rxd(rxd),
    .txd(txd), .enabled(enabled), .panel_top(panel_top), .fault_rst_ext(fault_rst_ext), .fault_now(fault_now),
    .evt_bits(48'h0), .flash_rdata(flash_rdata), .flash_ack(flash_ack), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_rd(flash_rd), .flash_wr(flash_wr), .booted(booted),
    .hist_save(hist_save), .odo_clr_tube(), .odo_clr_dup(), .pg_reload(pg_reload), .prm_addr(prm_addr),
    .prm_data(prm_data), .fault_latch(fault_latch));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-letter command, CR, then the CR LF reply
  task automatic cmd(input logic [7:0] c);
    host_i.send(c);
    fork host_i.send(8'h0D); host_i.recv(r0); join
    host_i.recv(r1);
    #1;
    `CHK({r0, r1}, 16'h0D0A)
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #900_000 errors++;
    wrap_up;
  end
  task automatic boot_test;
    tick(300);
    `CHK(booted, 1'b1)
    prm_addr = 7'h05;
    tick(2);
    `CHK(prm_data, 12'hA55)
    $display("boot done");
  endtask
  task automatic panel_test;
    w0 = n_wr;
    panel_top = 1;
    tick(1);
    panel_top = 0;
    tick(300);
    `CHK(n_wr > w0, 1'b1)
    $display("panel save done");
  endtask
  task automatic fault_test;
    fault_now = 32'h10;
    fault_rst_ext = 1;
    tick(2);
    `CHK(fault_latch[4], 1'b1)
    fault_now = 32'h0;
    tick(1);
    fault_rst_ext = 0;
    fault_now = 32'h10;
    tick(2);
    fault_now = 32'h0;
    $display("fault latch done");
  endtask
  // The periodic history timer is sized so that Q lands in a quiet span
  task automatic flash_copy_test;
    w0 = n_wr;
    h0 = n_hist;
    cmd(8'h51);
    `CHK(n_wr > w0, 1'b1)
    `CHK(n_hist, h0 + 1)
    $display("flash copy done");
  endtask
  // Two periodic history saves fall inside the r command
  task automatic serial_reset_test;
    h0 = n_rl;
    enabled = 1;
    tick(300);
    w0 = n_wr;
    h1 = n_hist;
    cmd(8'h72);
    `CHK(fault_latch, 32'h0)
    `CHK(n_wr, w0)
    `CHK(n_rl, h0 + 1)
    `CHK(n_hist, h1 + 2)
    h0 = n_hist;
    enabled = 0;
    tick(3);
    `CHK(n_hist, h0 + 1)
    $display("serial reset done");
  endtask
  initial begin
    tick(6);
    sys_rst = 0;
    boot_test;
    panel_test;
    fault_test;
    flash_copy_test;
    serial_reset_test;
    wrap_up;
  end
endmodule
bind serial_cfg_cmd serial_cfg_cmd_monitor serial_cfg_cmd_monitor_i (.clk(clk), .sys_rst(sys_rst),
  .enabled(enabled), .panel_top(panel_top), .fault_rst_ext(fault_rst_ext), .fault_now(fault_now),
  .flash_rd(flash_rd), .flash_wr(flash_wr), .booted(booted), .hist_save(hist_save),
  .pg_reload(pg_reload), .fault_latch(fault_latch));
